// File: mdiom_top.sv
`timescale 1ns/1ps
`include "mdiom_defs.svh"

module mdiom_top
#(
    parameter int DIV_W = 6
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic mgmt_clk_in,
    input wire logic mdio_line_in,
    output logic mgmt_data_in,
    output logic mgmt_data_in_oe_n
);
    import mdiom_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    mdiom_state_t state_reg;
    logic wr_op_reg;
    logic [DIV_W-1:0] div_reg;
    logic [9:0] addr_reg;
    logic [15:0] wdata_reg;
    logic [15:0] rdata_reg;
    logic done_reg;
    logic refused_reg;
    logic [5:0] bit_cnt_reg;
    logic [31:0] frame_reg;
    logic ph_write_reg;
    logic [7:0] ph_addr_reg;
    logic mdio_sync;
    logic mdc_rise;
    logic mdc_fall;
    logic [7:0] hi_cnt_reg;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire addr_ph = hsel && hready && htrans[1];
    wire [7:0] rd_sel = haddr[7:0];
    wire wr_ctrl = ph_write_reg && (ph_addr_reg == `MDIOM_OFF_CTRL);
    wire wr_addr = ph_write_reg && (ph_addr_reg == `MDIOM_OFF_ADDR);
    wire wr_wdata = ph_write_reg && (ph_addr_reg == `MDIOM_OFF_WDATA);
    wire wr_stat = ph_write_reg && (ph_addr_reg == `MDIOM_OFF_STATUS);
    wire busy = (state_reg == MDIOM_RUN);
    wire start_req = wr_ctrl && hwdata[`MDIOM_CTRL_START_BIT];
    wire [DIV_W-1:0] new_div = hwdata[`MDIOM_CTRL_DIV_MSB:`MDIOM_CTRL_DIV_LSB];
    wire [DIV_W-1:0] min_div = DIV_W'(`MDIOM_MIN_DIV);
    // Start only when idle and the divider keeps the clock legal
    wire start_ok = start_req && !busy && (div_reg >= min_div);
    wire start_bad = start_req && !start_ok;
    wire new_wr = hwdata[`MDIOM_CTRL_WR_BIT];
    wire [31:0] frame_load = {`MDIOM_START_CODE,
        (new_wr ? `MDIOM_OP_WRITE : `MDIOM_OP_READ),
        addr_reg[`MDIOM_ADDR_PHY_MSB:`MDIOM_ADDR_PHY_LSB],
        addr_reg[`MDIOM_ADDR_REG_MSB:`MDIOM_ADDR_REG_LSB],
        `MDIOM_TA_CODE, wdata_reg};

    // Status and read mux
    wire [31:0] stat_word = {29'h0, refused_reg, done_reg, busy};
    wire [31:0] ctrl_word = {18'h0, div_reg, 6'h0, 1'b0, wr_op_reg};
    wire [31:0] rd_word =
        (rd_sel == `MDIOM_OFF_CTRL) ? ctrl_word :
        (rd_sel == `MDIOM_OFF_ADDR) ? {22'h0, addr_reg} :
        (rd_sel == `MDIOM_OFF_WDATA) ? {16'h0, wdata_reg} :
        (rd_sel == `MDIOM_OFF_RDATA) ? {16'h0, rdata_reg} :
        (rd_sel == `MDIOM_OFF_STATUS) ? stat_word : 32'h0;

    // ----------------------------------------
    // Frame sequencing terms
    // ----------------------------------------
    // Frame ends on the fall after bit 63, so the last high phase stays full length
    wire last_fall = busy && mdc_fall && (bit_cnt_reg == 6'(`MDIOM_LAST_BIT));
    wire [5:0] cnt_step = bit_cnt_reg + 6'h01;
    // Preamble ones, then the field word MSB first
    wire next_bit = (cnt_step < 6'(`MDIOM_PRE_BITS)) ? 1'b1 : frame_reg[~cnt_step[4:0]];
    // Release from the first turnaround bit of a read
    wire next_rel = !wr_op_reg && (cnt_step >= 6'(`MDIOM_TA_FIRST_BIT));
    wire capture = busy && mdc_rise && !wr_op_reg
        && (bit_cnt_reg >= 6'(`MDIOM_DATA_FIRST_BIT));

    // ----------------------------------------
    // Submodules
    // ----------------------------------------
    mdiom_sync u_sync
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(mdio_line_in),
        .sync_out(mdio_sync)
    );

    // Clock runs only during a frame, and we supply it ourselves
    mdiom_clkdiv #(.DIV_W(DIV_W)) u_div
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(busy),
        .div(div_reg),
        .mdc(mgmt_clk_in),
        .rise_pulse(mdc_rise),
        .fall_pulse(mdc_fall)
    );

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    // Address phase capture and zero-wait answer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_write_reg <= 1'b0;
            ph_addr_reg <= 8'h00;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            ph_write_reg <= addr_ph && hwrite;
            ph_addr_reg <= haddr[7:0];
            hrdata <= (addr_ph && !hwrite) ? rd_word : 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Configuration registers; frame fields locked while busy
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_reg <= `MDIOM_DIV_RESET;
            addr_reg <= `MDIOM_ADDR_RESET;
            wdata_reg <= `MDIOM_DATA_RESET;
        end
        else
        begin
            if (wr_ctrl && !busy)
                div_reg <= new_div;
            if (wr_addr && !busy)
                addr_reg <= hwdata[9:0];
            if (wr_wdata && !busy)
                wdata_reg <= hwdata[15:0];
        end
    end

    // Sticky flags: a set in the clearing cycle wins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            done_reg <= 1'b0;
            refused_reg <= 1'b0;
        end
        else
        begin
            done_reg <= last_fall
                || (done_reg && !(wr_stat && hwdata[`MDIOM_STAT_DONE_BIT]));
            refused_reg <= start_bad
                || (refused_reg && !(wr_stat && hwdata[`MDIOM_STAT_REFUSED_BIT]));
        end
    end

    // ----------------------------------------
    // Frame engine
    // ----------------------------------------
    // State, opcode and bit counter
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg <= MDIOM_IDLE;
            wr_op_reg <= 1'b0;
            bit_cnt_reg <= 6'h00;
            frame_reg <= 32'h0;
        end
        else
        begin
            unique case (state_reg)
                MDIOM_IDLE:
                begin
                    if (start_ok)
                    begin
                        state_reg <= MDIOM_RUN;
                        wr_op_reg <= new_wr;
                        bit_cnt_reg <= 6'h00;
                        frame_reg <= frame_load;
                    end
                end
                MDIOM_RUN:
                begin
                    if (last_fall)
                        state_reg <= MDIOM_IDLE;
                    else if (mdc_fall)
                        bit_cnt_reg <= cnt_step;
                end
            endcase
        end
    end

    // Pin drive changes at an accepted start and otherwise on falling clock edges only
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mgmt_data_in <= 1'b1;
            mgmt_data_in_oe_n <= 1'b1;
        end
        else if (start_ok)
        begin
            mgmt_data_in <= 1'b1;
            mgmt_data_in_oe_n <= 1'b0;
        end
        else if (last_fall)
        begin
            mgmt_data_in <= 1'b1;
            mgmt_data_in_oe_n <= 1'b1;
        end
        else if (busy && mdc_fall)
        begin
            mgmt_data_in <= next_bit;
            mgmt_data_in_oe_n <= next_rel;
        end
    end

    // Read data shifted in on rising clock edges
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata_reg <= `MDIOM_DATA_RESET;
        else if (capture)
            rdata_reg <= {rdata_reg[14:0], mdio_sync};
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // High-time counter for the clock rate check
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hi_cnt_reg <= 8'h00;
        else
            hi_cnt_reg <= mgmt_clk_in ? hi_cnt_reg + 8'h01 : 8'h00;
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence frame_begins;
        $rose(busy);
    endsequence

    sequence frame_ends;
        last_fall;
    endsequence

    mdc_rate_a: assert property ($fell(mgmt_clk_in) |->
        hi_cnt_reg >= 8'(`MDIOM_MIN_DIV + 1))
        else $error("management clock high time too short");
    start_cause_a: assert property (frame_begins |-> $past(start_ok))
        else $error("frame began without a legal start");
    op_field_a: assert property (frame_begins |->
        frame_reg[29:28] == (wr_op_reg ? `MDIOM_OP_WRITE : `MDIOM_OP_READ))
        else $error("opcode field does not match request");
    addr_field_a: assert property (frame_begins |->
        frame_reg[27:18] == addr_reg)
        else $error("address fields do not match register");
    ta_release_a: assert property (busy && !wr_op_reg
        && bit_cnt_reg >= 6'(`MDIOM_TA_FIRST_BIT) |-> mgmt_data_in_oe_n)
        else $error("master drives line after read turnaround");
    preamble_a: assert property (busy && bit_cnt_reg < 6'(`MDIOM_PRE_BITS)
        |-> mgmt_data_in && !mgmt_data_in_oe_n)
        else $error("preamble bit not a driven one");
    done_flag_a: assert property (frame_ends |=> done_reg && !busy)
        else $error("done not raised at frame end");
    div_zero_a: assert property (div_reg == `MDIOM_DIV_RESET |-> !start_ok)
        else $error("frame started with zero divider");
    clk_idle_a: assert property (!busy [*2] |-> !mgmt_clk_in)
        else $error("management clock runs outside a frame");
    rd_shift_a: assert property (capture |=>
        rdata_reg[0] == $past(mdio_sync))
        else $error("read bit not captured");
endmodule

// File: mdiom_defs.svh
`ifndef MDIOM_DEFS_SVH
`define MDIOM_DEFS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define MDIOM_OFF_CTRL 8'h00
`define MDIOM_OFF_ADDR 8'h04
`define MDIOM_OFF_WDATA 8'h08
`define MDIOM_OFF_RDATA 8'h0c
`define MDIOM_OFF_STATUS 8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MDIOM_CTRL_WR_BIT 0
`define MDIOM_CTRL_START_BIT 1
`define MDIOM_CTRL_DIV_LSB 8
`define MDIOM_CTRL_DIV_MSB 13
`define MDIOM_ADDR_REG_LSB 0
`define MDIOM_ADDR_REG_MSB 4
`define MDIOM_ADDR_PHY_LSB 5
`define MDIOM_ADDR_PHY_MSB 9
`define MDIOM_STAT_BUSY_BIT 0
`define MDIOM_STAT_DONE_BIT 1
`define MDIOM_STAT_REFUSED_BIT 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MDIOM_DIV_RESET 6'h00
`define MDIOM_ADDR_RESET 10'h000
`define MDIOM_DATA_RESET 16'h0000

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define MDIOM_START_CODE 2'h1
`define MDIOM_OP_WRITE 2'h1
`define MDIOM_OP_READ 2'h2
`define MDIOM_TA_CODE 2'h2
`define MDIOM_PRE_BITS 32
`define MDIOM_TA_FIRST_BIT 46
`define MDIOM_DATA_FIRST_BIT 48
`define MDIOM_LAST_BIT 63

// ----------------------------------------
// Timing
// ----------------------------------------
`define MDIOM_CLK_HZ 100000000
`define MDIOM_MDC_MAX_HZ 2500000
`define MDIOM_MIN_DIV \
    (((`MDIOM_CLK_HZ + 2 * `MDIOM_MDC_MAX_HZ - 1) / (2 * `MDIOM_MDC_MAX_HZ)) - 1)

`endif

// File: mdiom_pkg.sv
package mdiom_pkg;
    // Frame engine states
    typedef enum logic [0:0]
    {
        MDIOM_IDLE,
        MDIOM_RUN
    } mdiom_state_t;
endpackage

// File: mdiom_sync.sv
`timescale 1ns/1ps

module mdiom_sync
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic async_in,
    output logic sync_out
);
    logic stage1_reg;

    // Two-flop synchroniser, resets to idle-high line level
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stage1_reg <= 1'b1;
            sync_out <= 1'b1;
        end
        else
        begin
            stage1_reg <= async_in;
            sync_out <= stage1_reg;
        end
    end
endmodule

// File: mdiom_clkdiv.sv
`timescale 1ns/1ps

module mdiom_clkdiv
#(
    parameter int DIV_W = 6
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic [DIV_W-1:0] div,
    output logic mdc,
    output logic rise_pulse,
    output logic fall_pulse
);
    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    wire terminal = (cnt_reg == div);

    // Half period is div+1 host clocks
    assign cnt_next = terminal ? '0 : cnt_reg + 1'b1;

    // Counter, clock and edge markers; clock parks low when idle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_reg <= '0;
            mdc <= 1'b0;
            rise_pulse <= 1'b0;
            fall_pulse <= 1'b0;
        end
        else
        begin
            cnt_reg <= run ? cnt_next : '0;
            mdc <= run ? (mdc ^ terminal) : 1'b0;
            rise_pulse <= run && terminal && !mdc;
            fall_pulse <= run && terminal && mdc;
        end
    end
endmodule

// File: mdiom_phy_model.sv
`timescale 1ns/1ps

module mdiom_phy_model
#(
    parameter bit IGNORE_ZERO = 1'b0
)
(
    input wire logic mgmt_clk,
    input wire logic line,
    input wire logic [4:0] strap,
    output logic drv_bit,
    output logic drv_en
);
    logic [15:0] mem [32];
    logic [15:0] sh = 16'h0000;
    logic [11:0] hdr = 12'h000;
    int pos = 0;
    int ones = 0;
    wire logic match = (hdr[9:5] == strap) || (hdr[9:5] == 5'h00 && !IGNORE_ZERO);

    // --------------------------------
    // Register file start-up values
    // --------------------------------
    initial
    begin
        foreach (mem[i]) mem[i] = 16'h0000;
        drv_en = 1'b0;
        drv_bit = 1'b1;
    end

    // Frame bits taken on the rising clock edge
    always @(posedge mgmt_clk)
    begin
        if (pos == 0)
        begin
            if (line)
                ones <= ones + 1;
            else
            begin
                if (ones >= 32) pos <= 33;
                ones <= 0;
            end
        end
        else
        begin
            sh <= {sh[14:0], line};
            pos <= (pos == 63) ? 0 : pos + 1;
            if (pos == 45) hdr <= {sh[10:0], line};
            if (pos == 63 && hdr[11:10] == 2'h1 && match) mem[hdr[4:0]] <= {sh[14:0], line};
        end
    end

    // Turnaround low, then read data MSB first, after falling edges
    always @(negedge mgmt_clk)
    begin
        drv_en <= (pos >= 47) && hdr[11:10] == 2'h2 && match;
        drv_bit <= (pos >= 48) ? mem[hdr[4:0]][63 - pos] : 1'b0;
    end
endmodule

// File: testbench.sv
`timescale 1ns/1ps

module testbench;
    localparam logic [4:0] STRAP = 5'h03;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [5:0] div = 6'h00;
    wire logic hready;
    wire logic hresp;
    wire logic [31:0] hrdata;
    wire logic mgmt_clk_in;
    wire logic mgmt_data_in;
    wire logic mgmt_data_in_oe_n;
    wire logic phy_bit;
    wire logic phy_en;
    int errors = 0;
    int compares = 0;
    int rises = 0;
    int last_rise = 0;
    int per = 0;
    int cyc = 0;
    logic mclk_q = 1'b0;
    logic oe_bad = 1'b0;
    logic rd_mode = 1'b0;

    // Shared line with pull-up, resolved from both enables
    wire logic mdio_line = !mgmt_data_in_oe_n ? mgmt_data_in : (phy_en ? phy_bit : 1'b1);

    mdiom_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .mgmt_clk_in(mgmt_clk_in),
        .mdio_line_in(mdio_line), .mgmt_data_in(mgmt_data_in),
        .mgmt_data_in_oe_n(mgmt_data_in_oe_n));

    mdiom_phy_model i_phy (.mgmt_clk(mgmt_clk_in), .line(mdio_line), .strap(STRAP),
        .drv_bit(phy_bit), .drv_en(phy_en));

    initial
    begin
        forever #5 hclk = ~hclk;
    end

    // --------------------------------
    // Link clock monitor
    // --------------------------------
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        mclk_q <= mgmt_clk_in;
        if (mgmt_clk_in && !mclk_q)
        begin
            rises <= rises + 1;
            per <= cyc - last_rise;
            last_rise <= cyc;
            if (mgmt_data_in_oe_n !== (rd_mode && rises >= 46)) oe_bad <= 1'b1;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One single AHB-Lite transfer, entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic frame(input logic wr, input logic [4:0] phy, input logic [4:0] ra,
        input logic [15:0] wd, output logic [15:0] rd);
        logic [31:0] v;
        bus(1'b1, 8'h04, {22'h0, phy, ra}, v);
        bus(1'b1, 8'h08, {16'h0, wd}, v);
        rd_mode = !wr;
        rises = 0;
        oe_bad = 1'b0;
        bus(1'b1, 8'h00, {18'h0, div, 6'h0, 1'b1, wr}, v);
        bus(1'b0, 8'h10, 32'h0, v);
        check(v[1:0], 2'h1);
        do bus(1'b0, 8'h10, 32'h0, v); while (v[1] !== 1'b1);
        check(rises, 64);
        check(per, 2 * (div + 1));
        check(oe_bad, 1'b0);
        check(mgmt_clk_in, 1'b0);
        bus(1'b1, 8'h10, 32'h2, v);
        bus(1'b0, 8'h10, 32'h0, v);
        check(v, 32'h0);
        bus(1'b0, 8'h0c, 32'h0, v);
        rd = v[15:0];
    endtask

    task automatic t_reset();
        logic [31:0] v;
        check({hresp, mgmt_clk_in, mgmt_data_in_oe_n}, 3'h1);
        bus(1'b0, 8'h00, 32'h0, v);
        check(v[13:8], 6'h00);
        bus(1'b0, 8'h20, 32'h0, v);
        check(v, 32'h0);
        bus(1'b1, 8'h00, 32'h2, v);
        bus(1'b0, 8'h10, 32'h0, v);
        check(v, 32'h4);
        check(rises, 0);
        bus(1'b1, 8'h10, 32'h4, v);
    endtask

    task automatic t_fast_refused();
        logic [31:0] v;
        div = 6'd18;
        bus(1'b1, 8'h00, {18'h0, div, 8'h00}, v);
        bus(1'b1, 8'h00, {18'h0, div, 8'h02}, v);
        bus(1'b0, 8'h10, 32'h0, v);
        check(v, 32'h4);
        check(rises, 0);
        bus(1'b1, 8'h10, 32'h4, v);
    endtask

    task automatic t_write_read();
        logic [31:0] v;
        logic [15:0] r;
        div = 6'd19;
        bus(1'b1, 8'h00, {18'h0, div, 8'h00}, v);
        frame(1'b1, STRAP, 5'h05, 16'h1140, r);
        check(i_phy.mem[5], 16'h1140);
        frame(1'b0, STRAP, 5'h05, 16'h0000, r);
        check(r, 16'h1140);
    endtask

    task automatic t_bcast_vendor();
        logic [31:0] v;
        logic [15:0] r;
        div = 6'd25;
        bus(1'b1, 8'h00, {18'h0, div, 8'h00}, v);
        frame(1'b1, 5'h00, 5'h1f, 16'ha5c3, r);
        frame(1'b0, STRAP, 5'h1f, 16'h0000, r);
        check(r, 16'ha5c3);
        frame(1'b0, 5'h09, 5'h1f, 16'h0000, r);
        check(r, 16'hffff);
    endtask

    task automatic finish_test();
        if (errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // --------------------------------
    // Main sequence and watchdog
    // --------------------------------
    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_fast_refused();
        t_write_read();
        t_bcast_vendor();
        finish_test();
    end

    initial
    begin
        repeat (40000) @(posedge hclk);
        errors++;
        finish_test();
    end
endmodule
